// ===== bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import wdrc_pkg::*;
  localparam int REL [4] = '{20, 30, 40, 50};
  localparam int LIMIT   = 20000;
  logic clk, rst_n, key_c, wk_c, bus_c, bat_c, sok, awvalid, wvalid, bready, arvalid, rready;
  logic [23:0] eot;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        awready, wready, bvalid, arready, rvalid, supply, relay, dsw_out, dsw_oe;
  wire         key_p, wk_p, bus_p, bat_p, dsw_pin;
  wdrc_status_t status;
  int err_count, checked, cnt;
  wdrc_partner u_far (.key_i(key_c), .wake_i(wk_c), .bus_i(bus_c), .bat_low_i(bat_c),
    .dsw_oe_i(dsw_oe), .key_o(key_p), .wake_o(wk_p), .bus_o(bus_p), .bat_low_o(bat_p),
    .dsw_pin_o(dsw_pin));
  wdrc_top #(.REL_DLY0_CYC(REL[0]), .REL_DLY1_CYC(REL[1]), .REL_DLY2_CYC(REL[2]),
    .REL_DLY3_CYC(REL[3])) dut (.CLK_I(clk), .RESETN_I(rst_n), .KEY_I(key_p),
    .WAKE_PIN_INPUT_I(wk_p), .BUS_WAKE_I(bus_p), .BAT_BELOW_TH_I(bat_p), .SUPPLY_OK_I(sok),
    .EOT_COUNT_I(eot), .SUPPLY_REQ_O(supply), .MAIN_RELAY_O(relay), .DSW_OUT_O(dsw_out),
    .DSW_OE_O(dsw_oe), .STATUS_O(status), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));
  // ---------------------------------------------------------------
  // clock, timeout and verdict
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  // cuts a hung wait short
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (cnt == LIMIT) begin
      err_count++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask : rd
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    {key_c, wk_c, bus_c, bat_c, awvalid, wvalid, bready, arvalid, rready} = 9'h000;
    {awaddr, araddr, wdata, eot, err_count, checked, cnt} = '0;
    sok   = 1'b1;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and unmapped or read-only places
    rd(ADDR_STAT, 32'h0, RESP_OKAY);
    rd(ADDR_CFG, 32'h0, RESP_OKAY);
    rd(ADDR_EOTCMP, 32'h0, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'h3, RESP_SLVERR);
    wr(ADDR_STAT, 32'h7F, RESP_OKAY);
    rd(ADDR_STAT, 32'h0, RESP_OKAY);
    chk({30'h0, supply, relay}, 32'h0);
    done("reset");
    // short wake pulse is filtered, then a real wake with battery high
    wk_c <= 1'b1;
    cyc(20);
    wk_c <= 1'b0;
    cyc(110);
    rd(ADDR_STAT, 32'h0, RESP_OKAY);
    wk_c <= 1'b1;
    cyc(110);
    rd(ADDR_STAT, 32'h46, RESP_OKAY);
    chk({30'h0, supply, relay}, 32'h2);
    // clear while pin is stuck high, no new wake until a fresh edge
    wr(ADDR_CMD, 32'h1, RESP_OKAY);
    rd(ADDR_STAT, 32'h02, RESP_OKAY);
    cyc(110);
    rd(ADDR_STAT, 32'h02, RESP_OKAY);
    wk_c <= 1'b0;
    cyc(110);
    rd(ADDR_STAT, 32'h0, RESP_OKAY);
    wk_c <= 1'b1;
    cyc(110);
    rd(ADDR_STAT, 32'h46, RESP_OKAY);
    wr(ADDR_CMD, 32'h1, RESP_OKAY);
    wk_c <= 1'b0;
    cyc(110);
    rd(ADDR_STAT, 32'h0, RESP_OKAY);
    done("wake pin");
    // bus wake with battery low, then relay command without ignition
    bat_c <= 1'b1;
    cyc(10);
    bus_c <= 1'b1;
    cyc(10);
    rd(ADDR_STAT, 32'h70, RESP_OKAY);
    wr(ADDR_CMD, 32'h0, RESP_OKAY);
    rd(ADDR_STAT, 32'h50, RESP_OKAY);
    wr(ADDR_CMD, 32'h2, RESP_OKAY);
    chk({31'h0, relay}, 32'h1);
    bus_c <= 1'b0;
    bat_c <= 1'b0;
    cyc(10);
    wr(ADDR_CMD, 32'h1, RESP_OKAY);
    rd(ADDR_STAT, 32'h0, RESP_OKAY);
    done("bus wake");
    // ignition with each release delay
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CFG, i, RESP_OKAY);
      key_c <= 1'b1;
      cyc(110);
      rd(ADDR_STAT, 32'h61, RESP_OKAY);
      chk({25'h0, status}, 32'h61);
      chk({31'h0, dsw_pin}, 32'h1);
      wr(ADDR_CMD, 32'h0, RESP_OKAY);
      chk({31'h0, relay}, 32'h1);
      key_c <= 1'b0;
      wait (status.key_level === 1'b0);
      n = 0;
      while (dsw_oe !== 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      chk(32'(n >= REL[i] && n <= REL[i] + 2), 32'h1);
      chk({31'h0, dsw_pin}, 32'h0);
    end
    // supply loss releases the delayed output while ignition is on
    key_c <= 1'b1;
    cyc(110);
    sok <= 1'b0;
    cyc(2);
    chk({30'h0, dsw_out, dsw_pin}, 32'h0);
    sok <= 1'b1;
    cyc(2);
    chk({30'h0, dsw_out, dsw_pin}, 32'h1);
    key_c <= 1'b0;
    cyc(110);
    done("ignition");
    // timer compare wake
    eot <= 24'h0001FF;
    wr(ADDR_EOTCMP, 32'h2, RESP_OKAY);
    rd(ADDR_EOTCMP, 32'h2, RESP_OKAY);
    rd(ADDR_STAT, 32'h0, RESP_OKAY);
    eot <= 24'h000200;
    cyc(3);
    rd(ADDR_STAT, 32'h48, RESP_OKAY);
    wr(ADDR_CMD, 32'h1, RESP_OKAY);
    rd(ADDR_STAT, 32'h48, RESP_OKAY);
    eot <= 24'h000201;
    wr(ADDR_CMD, 32'h1, RESP_OKAY);
    rd(ADDR_STAT, 32'h0, RESP_OKAY);
    done("timer");
    end_of_test();
  end
endmodule : tb
`default_nettype wire

// ===== bench/wdrc_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// ignition switch, wake line, comparator and output pin
// ---------------------------------------------------------------
module wdrc_partner (
  input  wire logic key_i,
  input  wire logic wake_i,
  input  wire logic bus_i,
  input  wire logic bat_low_i,
  input  wire logic dsw_oe_i,
  output logic      key_o,
  output logic      wake_o,
  output logic      bus_o,
  output logic      bat_low_o,
  output logic      dsw_pin_o
);
  // switch and line levels as the harness sets them
  assign key_o     = key_i;
  assign wake_o    = wake_i;
  assign bus_o     = bus_i;
  assign bat_low_o = bat_low_i;
  // open drain with external pull-up
  assign dsw_pin_o = dsw_oe_i ? 1'b0 : 1'b1;
endmodule : wdrc_partner
`default_nettype wire

// ===== rtl/wdrc_pkg.sv
// Notes on behaviour
// R1: any valid wake source (ignition, wake pin, bus wake, timer) starts up.
// R2: any wake present requests supply ramp-up; none keeps supply off.
// R3: ignition-caused start-up switches the main relay on unconditionally.
// R4: other wake sources switch relay on only when battery is below threshold.
// R5: wake clear resets held pin, timer and bus wake states.
// R6: ignition input is deglitched; filtered level is readable status.
// R7: delayed output copies ignition; falling edge delayed by selected release delay.
// R8: wake pin deglitched on both edges; filtered level is readable status.
// R9: filtered wake pin rising edge sets pin wake flag and wakes device.
// R10: wake clear resets pin wake flag; steady high cannot set it again.
// R11: low filtered wake pin returns pin wake machine to inactive, re-arming.
// R12: microcontroller must clear a stuck-high wake pin to allow sleep.
// R13: after start-up relay command rules relay unless ignition is high.
// R14: comparator mode sets timer wake flag when counter equals compare value.
// R15: all pin inputs are synchronised before filtering and edge detection.
package wdrc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_CFG    = 8'h04;
  localparam logic [7:0] ADDR_STAT   = 8'h08;
  localparam logic [7:0] ADDR_EOTCMP = 8'h0C;
  // command register zero bits
  localparam int BIT_WCLR  = 0;
  localparam int BIT_RLYON = 1;
  // release delay select field in config zero
  localparam int BIT_RDS_LO = 0;
  localparam logic [1:0] RDS_RESET = 2'h0;
  localparam logic [15:0] EOTCMP_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ     = 10;
  localparam int KEY_FILT_US = 10;
  localparam int WK_FILT_US  = 10;
  localparam int KEY_FILT_CYC = KEY_FILT_US * CLK_MHZ;
  localparam int WK_FILT_CYC  = WK_FILT_US * CLK_MHZ;
  localparam int REL_DLY0_MS = 100;
  localparam int REL_DLY1_MS = 200;
  localparam int REL_DLY2_MS = 300;
  localparam int REL_DLY3_MS = 400;
  localparam int CYC_PER_MS  = CLK_MHZ * 1000;
  // timer counter shift per compare step (256 ticks, 2 s at 1/128 s)
  localparam int EOT_SHIFT = 8;
  // ---------------------------------------------------------------
  // status carrier, bit 6 first
  // ---------------------------------------------------------------
  typedef struct packed {
    logic supply_req;
    logic main_relay_state;
    logic bus_wake_flag;
    logic timer_wake_flag;
    logic internal_pin_wake_flag;
    logic wake_pin_level;
    logic key_level;
  } wdrc_status_t;
  typedef enum logic [1:0] {PW_IDLE, PW_ACTIVE, PW_CLEARED} wdrc_pw_t;
  typedef enum logic {ST_SLEEP, ST_RUN} wdrc_run_t;
endpackage : wdrc_pkg

// ===== rtl/wdrc_top.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// synchroniser and deglitch filter
// ---------------------------------------------------------------
module wdrc_deglitch #(
  parameter int unsigned CYC = 1
) (
  input  wire logic CLK_I,
  input  wire logic RESETN_I,
  input  wire logic PIN_I,
  output logic      LEVEL_O
);
  logic [2:0]  sync_ff;
  logic [15:0] cnt_ff;
  logic        lvl_ff;
  // three-stage synchroniser
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sync_ff <= 3'h0;
    end else begin
      sync_ff <= {sync_ff[1:0], PIN_I}; // R15
    end
  end
  // level flips after CYC agreeing samples, both edges
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cnt_ff <= 16'h0000;
      lvl_ff <= 1'b0;
    end else if (sync_ff[1] == sync_ff[2] && sync_ff[2] != lvl_ff) begin
      if (32'(cnt_ff) >= CYC - 1) begin
        lvl_ff <= sync_ff[2]; // R6 R8
        cnt_ff <= 16'h0000;
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end else begin
      cnt_ff <= 16'h0000;
    end
  end
  assign LEVEL_O = lvl_ff;
endmodule : wdrc_deglitch

// ---------------------------------------------------------------
// wake detection and relay control
// ---------------------------------------------------------------
module wdrc_top #(
  parameter int unsigned REL_DLY0_CYC = wdrc_pkg::REL_DLY0_MS * wdrc_pkg::CYC_PER_MS,
  parameter int unsigned REL_DLY1_CYC = wdrc_pkg::REL_DLY1_MS * wdrc_pkg::CYC_PER_MS,
  parameter int unsigned REL_DLY2_CYC = wdrc_pkg::REL_DLY2_MS * wdrc_pkg::CYC_PER_MS,
  parameter int unsigned REL_DLY3_CYC = wdrc_pkg::REL_DLY3_MS * wdrc_pkg::CYC_PER_MS
) (
  input  wire logic        CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        KEY_I,
  input  wire logic        WAKE_PIN_INPUT_I,
  input  wire logic        BUS_WAKE_I,
  input  wire logic        BAT_BELOW_TH_I,
  input  wire logic        SUPPLY_OK_I,
  input  wire logic [23:0] EOT_COUNT_I,
  output logic             SUPPLY_REQ_O,
  output logic             MAIN_RELAY_O,
  output logic             DSW_OUT_O,
  output logic             DSW_OE_O,
  output wdrc_pkg::wdrc_status_t STATUS_O,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I
);
  import wdrc_pkg::*;

  logic key_lvl, wk_lvl, bus_lvl, bat_low;
  logic wk_prev_ff, bus_prev_ff;
  wdrc_pw_t pw_ff;
  wdrc_run_t run_ff;
  logic timer_flag_ff, bus_flag_ff, relay_ff, supply_ff, dsw_ff;
  logic [1:0] rds_ff;
  logic [15:0] cmp_ff;
  logic [22:0] dly_cnt_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_go, rd_go, wk_rise, bus_rise, eot_eq, wake_clr, rly_wr;
  logic pin_flag, any_wake, other_wake;
  logic [31:0] rel_cyc;
  wdrc_status_t stat;
  // ---------------------------------------------------------------
  // input conditioning
  // ---------------------------------------------------------------
  wdrc_deglitch #(.CYC(KEY_FILT_CYC)) u_key (
    .CLK_I(CLK_I), .RESETN_I(RESETN_I), .PIN_I(KEY_I), .LEVEL_O(key_lvl));
  wdrc_deglitch #(.CYC(WK_FILT_CYC)) u_wk (
    .CLK_I(CLK_I), .RESETN_I(RESETN_I), .PIN_I(WAKE_PIN_INPUT_I), .LEVEL_O(wk_lvl));
  wdrc_deglitch #(.CYC(1)) u_bus (
    .CLK_I(CLK_I), .RESETN_I(RESETN_I), .PIN_I(BUS_WAKE_I), .LEVEL_O(bus_lvl));
  wdrc_deglitch #(.CYC(1)) u_bat (
    .CLK_I(CLK_I), .RESETN_I(RESETN_I), .PIN_I(BAT_BELOW_TH_I), .LEVEL_O(bat_low));
  // edge history of filtered levels
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wk_prev_ff  <= 1'b0;
      bus_prev_ff <= 1'b0;
    end else begin
      wk_prev_ff  <= wk_lvl;
      bus_prev_ff <= bus_lvl;
    end
  end
  // ---------------------------------------------------------------
  // bus slave handshakes
  // ---------------------------------------------------------------
  assign wr_go = S_AXI_AWVALID_I & S_AXI_WVALID_I & ~bvalid_ff;
  assign rd_go = S_AXI_ARVALID_I & ~rvalid_ff;
  assign S_AXI_AWREADY_O = wr_go;
  assign S_AXI_WREADY_O  = wr_go;
  assign S_AXI_ARREADY_O = rd_go;
  assign wake_clr = wr_go & (S_AXI_AWADDR_I == ADDR_CMD) & S_AXI_WSTRB_I[0]
                    & S_AXI_WDATA_I[BIT_WCLR];
  assign rly_wr = wr_go & (S_AXI_AWADDR_I == ADDR_CMD) & S_AXI_WSTRB_I[0];
  // write response
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (S_AXI_AWADDR_I == ADDR_CMD || S_AXI_AWADDR_I == ADDR_CFG
                   || S_AXI_AWADDR_I == ADDR_STAT || S_AXI_AWADDR_I == ADDR_EOTCMP)
                   ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      bvalid_ff <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rds_ff <= RDS_RESET;
      cmp_ff <= EOTCMP_RESET;
    end else if (wr_go) begin
      if (S_AXI_AWADDR_I == ADDR_CFG && S_AXI_WSTRB_I[0]) begin
        rds_ff <= S_AXI_WDATA_I[BIT_RDS_LO +: 2];
      end
      if (S_AXI_AWADDR_I == ADDR_EOTCMP) begin
        if (S_AXI_WSTRB_I[0]) cmp_ff[7:0]  <= S_AXI_WDATA_I[7:0];
        if (S_AXI_WSTRB_I[1]) cmp_ff[15:8] <= S_AXI_WDATA_I[15:8];
      end
    end
  end

  // read data path
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      unique case (S_AXI_ARADDR_I)
        ADDR_CMD:    rdata_ff <= {30'h0, relay_ff, 1'b0};
        ADDR_CFG:    rdata_ff <= {30'h0, rds_ff};
        ADDR_STAT:   rdata_ff <= {25'h0, stat};
        ADDR_EOTCMP: rdata_ff <= {16'h0, cmp_ff};
        default: begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY_I) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign S_AXI_BVALID_O = bvalid_ff;
  assign S_AXI_BRESP_O  = bresp_ff;
  assign S_AXI_RVALID_O = rvalid_ff;
  assign S_AXI_RDATA_O  = rdata_ff;
  assign S_AXI_RRESP_O  = rresp_ff;
  // ---------------------------------------------------------------
  // wake sources
  // ---------------------------------------------------------------
  assign wk_rise  = wk_lvl & ~wk_prev_ff;
  assign bus_rise = bus_lvl & ~bus_prev_ff;
  assign eot_eq   = (cmp_ff != 16'h0000)
                    && (EOT_COUNT_I == {cmp_ff, 8'h00});
  // pin wake state machine
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pw_ff <= PW_IDLE;
    end else begin
      unique case (pw_ff)
        PW_IDLE:    if (wk_rise) pw_ff <= PW_ACTIVE; // R9
        PW_ACTIVE:  if (!wk_lvl) pw_ff <= PW_IDLE; // R11
                    else if (wake_clr) pw_ff <= PW_CLEARED; // R5 R10
        PW_CLEARED: if (!wk_lvl) pw_ff <= PW_IDLE; // R11
        default:    pw_ff <= PW_IDLE;
      endcase
    end
  end
  assign pin_flag = (pw_ff == PW_ACTIVE);
  // timer and bus wake flags, set beats clear
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      timer_flag_ff <= 1'b0;
      bus_flag_ff   <= 1'b0;
    end else begin
      if (eot_eq) timer_flag_ff <= 1'b1; // R14
      else if (wake_clr) timer_flag_ff <= 1'b0; // R5
      if (bus_rise) bus_flag_ff <= 1'b1;
      else if (wake_clr) bus_flag_ff <= 1'b0; // R5
    end
  end

  // ---------------------------------------------------------------
  // start-up, supply and main relay
  // ---------------------------------------------------------------
  assign other_wake = pin_flag | timer_flag_ff | bus_flag_ff;
  assign any_wake   = key_lvl | other_wake; // R1
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      supply_ff <= 1'b0;
    end else begin
      supply_ff <= any_wake; // R2
    end
  end

  // relay decided at start-up, then by command unless ignition is high
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      run_ff   <= ST_SLEEP;
      relay_ff <= 1'b0;
    end else begin
      unique case (run_ff)
        ST_SLEEP: if (any_wake) begin
          run_ff   <= ST_RUN;
          relay_ff <= key_lvl | bat_low; // R3 R4
        end
        ST_RUN: if (!any_wake) begin
          run_ff   <= ST_SLEEP;
          relay_ff <= 1'b0;
        end else if (key_lvl) begin
          relay_ff <= 1'b1; // R13
        end else if (rly_wr) begin
          relay_ff <= S_AXI_WDATA_I[BIT_RLYON]; // R13
        end
      endcase
    end
  end
  assign SUPPLY_REQ_O = supply_ff;
  assign MAIN_RELAY_O = relay_ff;
  // ---------------------------------------------------------------
  // delayed switch output
  // ---------------------------------------------------------------
  always_comb begin
    unique case (rds_ff)
      2'h0: rel_cyc = 32'(REL_DLY0_CYC);
      2'h1: rel_cyc = 32'(REL_DLY1_CYC);
      2'h2: rel_cyc = 32'(REL_DLY2_CYC);
      2'h3: rel_cyc = 32'(REL_DLY3_CYC);
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dsw_ff     <= 1'b0;
      dly_cnt_ff <= 23'h000000;
    end else if (!SUPPLY_OK_I) begin
      dsw_ff     <= 1'b0;
      dly_cnt_ff <= 23'h000000;
    end else if (key_lvl) begin
      dsw_ff     <= 1'b1; // R7
      dly_cnt_ff <= 23'h000000;
    end else if (dsw_ff) begin
      if (32'(dly_cnt_ff) >= rel_cyc - 32'h1) begin
        dsw_ff <= 1'b0; // R7
      end else begin
        dly_cnt_ff <= dly_cnt_ff + 23'h000001;
      end
    end else begin
      dly_cnt_ff <= 23'h000000;
    end
  end
  // open drain: pull low while output is low
  assign DSW_OUT_O = 1'b0;
  assign DSW_OE_O  = ~dsw_ff;

  // ---------------------------------------------------------------
  // status
  // ---------------------------------------------------------------
  assign stat = '{supply_req: supply_ff, main_relay_state: relay_ff,
                  bus_wake_flag: bus_flag_ff, timer_wake_flag: timer_flag_ff,
                  internal_pin_wake_flag: pin_flag, wake_pin_level: wk_lvl,
                  key_level: key_lvl}; // R6 R8 R9
  assign STATUS_O = stat;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  supply_on_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R2
    any_wake |=> SUPPLY_REQ_O) else $error("supply not requested");
  supply_off_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R2
    !any_wake |=> !SUPPLY_REQ_O) else $error("supply on without wake");
  key_relay_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R3
    key_lvl |=> MAIN_RELAY_O) else $error("relay off with key");
  bat_gate_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R4
    (run_ff == ST_SLEEP && !key_lvl && other_wake && !bat_low) |=> !MAIN_RELAY_O)
    else $error("relay on with high battery");
  flag_clear_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R5
    (wake_clr && !eot_eq && !bus_rise && !wk_rise)
    |=> (!timer_flag_ff && !bus_flag_ff && !pin_flag))
    else $error("wake flags not cleared");
  pin_set_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R9
    (wk_rise && pw_ff == PW_IDLE) |=> pin_flag) else $error("pin wake not set");
  stuck_high_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R10
    (pw_ff == PW_CLEARED && wk_lvl) ##1 wk_lvl |-> !pin_flag)
    else $error("pin wake set without edge");
  rearm_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R11
    (!wk_lvl && pw_ff != PW_IDLE) |=> pw_ff == PW_IDLE) else $error("no rearm");
  timer_set_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R14
    eot_eq |=> timer_flag_ff) else $error("timer wake not set");
  dsw_rise_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R7
    (key_lvl && SUPPLY_OK_I) |=> !DSW_OE_O) else $error("delayed output not high");
  key_filter_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R6
    $rose(key_lvl) |-> $past(KEY_I, 4)) else $error("key edge unfiltered");
endmodule : wdrc_top
`default_nettype wire
